/* File: rtl/xfm_defs.svh */
/*
 * Offsets, field positions, reset values and fault codes of the translation
 * buffer fault and mapped access block.
 * Assumes it is included by bare name by the design file.
 */
`ifndef XFM_DEFS_SVH
`define XFM_DEFS_SVH
// ============================================================================
// Plain register offsets (outside the mapped array windows)
`define XFM_OFS_HIGH_STAGE 32'h0000_0000
`define XFM_OFS_LOW_STAGE  32'h0000_0004
`define XFM_OFS_FAULT_ADDR 32'h0000_0008
`define XFM_OFS_CONTROL    32'h0000_000C
`define XFM_OFS_EVENT_CODE 32'h0000_0010
`define XFM_OFS_SAVED_PC   32'h0000_0014
`define XFM_OFS_SAVED_STAT 32'h0000_0018
`define XFM_OFS_STATUS     32'h0000_001C
`define XFM_OFS_VEC_BASE   32'h0000_0020
// ============================================================================
// Mapped array windows, selected by address bits 31-24
`define XFM_ADDR_ARRAY_SEL 8'hF2
`define XFM_DATA_ARRAY_SEL 8'hF3
// ============================================================================
// Field positions
`define XFM_CTL_HASH_BIT   2
`define XFM_CTL_WAY_LSB    6
`define XFM_CTL_SGL_BIT    8
`define XFM_ST_PRIV_BIT    30
`define XFM_ST_BANK_BIT    29
`define XFM_ST_MASK_BIT    28
`define XFM_ASSOC_BIT      7
`define XFM_VALID_BIT      8
// ============================================================================
// Reset values, fault codes and handler offset
`define XFM_RST_STATUS     32'h7000_00F0
`define XFM_RST_ZERO       32'h0000_0000
`define XFM_CODE_INV_LOAD  12'h040
`define XFM_CODE_INV_STORE 12'h060
`define XFM_CODE_FIRST_WR  12'h080
`define XFM_VEC_OFFSET     32'h0000_0100
`endif

/* File: rtl/xfm_pkg.sv */
/*
 * Types shared by the translation buffer block: lookup request, fault
 * answer and one buffer entry.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package xfm_pkg;
  // ==========================================================================
  // Lookup request from the core pipeline
  typedef struct packed {
    logic [31:0] vaddr;      // Virtual address of the access
    logic        write;      // 1 = store, 0 = load or fetch
    logic [31:0] pc;         // Address of the accessing instruction
    logic [31:0] branch_pc;  // Address of the delayed branch, if in a slot
    logic        delay_slot; // Access issued from a delay slot
  } xfm_req_t;

  // Fault answer to the core
  typedef struct packed {
    logic        valid;      // One-cycle fault pulse
    logic [31:0] target;     // Handler entry address
  } xfm_fault_t;

  // One buffer entry: address part, then data part
  typedef struct packed {
    logic [21:0] virt_page_num;        // Virtual page number, address bits 31-10
    logic [7:0]  space_tag;  // Address space tag
    logic        present;    // Entry present flag
    logic [18:0] phys_frame_num;        // Physical frame number, bits 28-10
    logic [1:0]  rights;     // Access rights
    logic        page_size;  // 1 = 4 KB page, 0 = 1 KB page
    logic        cacheable;  // Cacheable
    logic        written;    // Page written flag
    logic        global_pg;  // Shared across spaces
  } xfm_entry_t;
endpackage : xfm_pkg

/* File: rtl/xfm_tlb.sv */
/*
 * Four-way, 32-set address translation buffer: invalid-entry and first-write
 * fault detection with their state updates, plus the mapped array port.
 * Assumes the core issues at most one lookup a cycle and a register master
 * that never overlaps read and write strobes.
 */
// Decided for this implementation: the address-and-strobe port and the address map.
// Notes on behaviour
// - Matching entry not present raises invalid fault
// - Invalid fault saves page and address
// - Invalid fault records faulting way
// - Invalid fault code 040 load, 060 store
// - Save fault pc, or delayed branch pc
// - Copy status into saved status first
// - Set privilege, mask and bank bits
// - Invalid fault branches to base plus 100
// - Store to clean permitted page faults
// - First-write saves page, address, code 080
// - First-write records way, branches base plus 100
// - Privileged access to mapped array windows
// - Array accesses are longword only
// - Index, way and window from address
// - Optional index hash with space tag
// - Associative write hits one way only
// - Associative compare uses lookup rules
// - Direct write goes to index and way
// - Address read returns fields, bits 16-12 zero
// - Writing zero present flag invalidates entry
`include "xfm_defs.svh"

module xfm_tlb (
  // Clock, reset, enable
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               ce,
  // Core lookup port
  input  wire logic               req_valid,
  input  wire xfm_pkg::xfm_req_t  req,
  input  wire logic               load_entry_op,
  output logic                    hit_q,
  output logic [31:0]             paddr_q,
  output xfm_pkg::xfm_fault_t     fault_q,
  // Register port
  input  wire logic [31:0]        reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [31:0]             reg_rdata_q,
  // Status view
  output logic [31:0]             status_word_q
);
  // ==========================================================================
  // State
  xfm_pkg::xfm_entry_t tlb_q [32][4]; // Entry storage, set by way
  logic [31:0] entry_high_stage_q;    // Page number and space tag
  logic [31:0] entry_low_stage_q;     // Frame and attribute fields
  logic [31:0] fault_addr_reg_q;      // Faulting virtual address
  logic [31:0] xlate_control_q;       // Hash, way pointer, single space
  logic [11:0] exc_event_code_q;      // Fault code
  logic [31:0] saved_pc_q;            // Return address
  logic [31:0] saved_status_q;        // Status before the fault
  logic [31:0] vector_base_q;         // Handler base

  logic       hash_en;                // Index hash enable
  logic       one_space;              // Single space mode
  logic       priv;                   // Privileged mode
  logic [1:0] way_ptr;                // Replacement way pointer
  assign hash_en   = xlate_control_q[`XFM_CTL_HASH_BIT];
  assign one_space = xlate_control_q[`XFM_CTL_SGL_BIT];
  assign way_ptr   = xlate_control_q[`XFM_CTL_WAY_LSB +: 2];
  assign priv      = status_word_q[`XFM_ST_PRIV_BIT];
  // ==========================================================================
  // Match function shared by lookup and associative write
  function automatic logic entry_match(input xfm_pkg::xfm_entry_t e,
                                       input logic [21:0] virt_page_num,
                                       input logic [7:0] tag,
                                       input logic one_space_i,
                                       input logic priv_i);
    logic page_ok;
    logic tag_ok;
    page_ok = 1'b0;
    tag_ok  = 1'b0;
    // A 4 KB page ignores bits 11-10 of the page number
    page_ok = e.page_size ? (e.virt_page_num[21:2] == virt_page_num[21:2]) : (e.virt_page_num == virt_page_num);
    // Shared pages and privileged single-space skip the tag
    tag_ok  = e.global_pg || (one_space_i && priv_i) || (e.space_tag == tag);
    return page_ok && tag_ok;
  endfunction : entry_match

  // Index, optionally hashed with the current space tag
  function automatic logic [4:0] make_index(input logic [4:0] vbits,
                                            input logic hash_i,
                                            input logic [7:0] tag);
    return hash_i ? (vbits ^ tag[4:0]) : vbits;
  endfunction : make_index

  // ==========================================================================
  // Lookup and fault detection
  logic [4:0] lk_idx;           // Lookup set
  logic [3:0] lk_hit;           // Per-way match
  logic [1:0] lk_way;           // Lowest matching way
  logic       lk_any;           // Any way matches
  logic       lk_allowed;       // Access rights permit the access
  logic       inv_fault;        // Invalid-entry fault this cycle
  logic       fw_fault;         // First-write fault this cycle
  logic       any_fault;        // Either fault
  xfm_pkg::xfm_entry_t lk_e;    // Selected entry

  assign lk_idx = make_index(req.vaddr[16:12], hash_en, entry_high_stage_q[7:0]);
  // Compare all four ways, take the lowest hit
  always_comb begin
    lk_hit = 4'h0;
    lk_way = 2'h0;
    for (int w = 3; w >= 0; w--) begin
      lk_hit[w] = entry_match(tlb_q[lk_idx][w], req.vaddr[31:10],
                              entry_high_stage_q[7:0], one_space, priv);
      if (lk_hit[w]) begin
        lk_way = 2'(w);
      end
    end
  end
  assign lk_any = |lk_hit;
  assign lk_e   = tlb_q[lk_idx][lk_way];
  // Rights: bit 1 opens user access, bit 0 opens writing
  assign lk_allowed = (priv || lk_e.rights[1]) && (!req.write || lk_e.rights[0]);
  assign inv_fault  = req_valid && lk_any && !lk_e.present;
  assign fw_fault   = req_valid && lk_any && lk_e.present && lk_allowed &&
                      req.write && !lk_e.written;
  assign any_fault  = inv_fault || fw_fault;
  // Translation result; misses and rights failures belong to other logic
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hit_q   <= 1'b0;
      paddr_q <= `XFM_RST_ZERO;
    end else if (ce) begin
      hit_q   <= req_valid && lk_any && lk_e.present && !any_fault;
      paddr_q <= lk_e.page_size ? {3'h0, lk_e.phys_frame_num[18:2], req.vaddr[11:0]}
                                : {3'h0, lk_e.phys_frame_num, req.vaddr[9:0]};
    end
  end
  // Fault pulse and handler address
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fault_q <= '0;
    end else if (ce) begin
      fault_q.valid <= any_fault;
      if (any_fault) begin
        fault_q.target <= vector_base_q + `XFM_VEC_OFFSET;
      end
    end
  end

  // ==========================================================================
  // Register port decode
  logic [7:0] win;           // Window select bits
  logic       aa_sel;        // Address array window
  logic       da_sel;        // Data array window
  logic [4:0] mp_idx;        // Mapped access set
  logic [1:0] mp_way;        // Mapped access way
  logic       assoc;         // Associative write
  logic [3:0] as_hit;        // Associative per-way match
  logic [1:0] as_way;        // Associative hit way
  // The port is one longword wide, so narrower accesses cannot be formed
  assign win    = reg_addr[31:24];
  // User mode cannot reach the windows; reads show zero
  assign aa_sel = priv && (win == `XFM_ADDR_ARRAY_SEL);
  assign da_sel = priv && (win == `XFM_DATA_ARRAY_SEL);
  assign mp_idx = make_index(reg_addr[16:12], hash_en, entry_high_stage_q[7:0]);
  assign mp_way = reg_addr[9:8];
  assign assoc  = reg_addr[`XFM_ASSOC_BIT];
  // Associative compare against the written page number
  always_comb begin
    as_hit = 4'h0;
    as_way = 2'h0;
    for (int w = 3; w >= 0; w--) begin
      as_hit[w] = entry_match(tlb_q[mp_idx][w], reg_wdata[31:10],
                              reg_wdata[7:0], one_space, priv);
      if (as_hit[w]) begin
        as_way = 2'(w);
      end
    end
  end

  // ==========================================================================
  // Entry storage writes: load op, address array, data array
  logic [4:0] ld_idx;        // Set for the load op
  assign ld_idx = make_index(entry_high_stage_q[16:12], hash_en, entry_high_stage_q[7:0]);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int s = 0; s < 32; s++) begin
        for (int w = 0; w < 4; w++) begin
          tlb_q[s][w] <= '0;
        end
      end
    end else if (ce) begin
      if (load_entry_op) begin
        // Stages into the way the pointer names
        tlb_q[ld_idx][way_ptr].virt_page_num       <= entry_high_stage_q[31:10];
        tlb_q[ld_idx][way_ptr].space_tag <= entry_high_stage_q[7:0];
        tlb_q[ld_idx][way_ptr].present   <= entry_low_stage_q[`XFM_VALID_BIT];
        tlb_q[ld_idx][way_ptr].phys_frame_num       <= entry_low_stage_q[28:10];
        tlb_q[ld_idx][way_ptr].rights    <= entry_low_stage_q[6:5];
        tlb_q[ld_idx][way_ptr].page_size <= entry_low_stage_q[4];
        tlb_q[ld_idx][way_ptr].cacheable <= entry_low_stage_q[3];
        tlb_q[ld_idx][way_ptr].written   <= entry_low_stage_q[2];
        tlb_q[ld_idx][way_ptr].global_pg <= entry_low_stage_q[1];
      end else if (reg_wr && aa_sel) begin
        if (assoc) begin
          // Only a hitting way is touched; a miss writes nothing
          if (|as_hit) begin
            tlb_q[mp_idx][as_way].virt_page_num       <= reg_wdata[31:10];
            tlb_q[mp_idx][as_way].space_tag <= reg_wdata[7:0];
            tlb_q[mp_idx][as_way].present   <= reg_wdata[`XFM_VALID_BIT];
          end
        end else begin
          tlb_q[mp_idx][mp_way].virt_page_num       <= reg_wdata[31:10];
          tlb_q[mp_idx][mp_way].space_tag <= reg_wdata[7:0];
          tlb_q[mp_idx][mp_way].present   <= reg_wdata[`XFM_VALID_BIT];
        end
      end else if (reg_wr && da_sel) begin
        // Data array carries the present flag too
        tlb_q[mp_idx][mp_way].present   <= reg_wdata[`XFM_VALID_BIT];
        tlb_q[mp_idx][mp_way].phys_frame_num       <= reg_wdata[28:10];
        tlb_q[mp_idx][mp_way].rights    <= reg_wdata[6:5];
        tlb_q[mp_idx][mp_way].page_size <= reg_wdata[4];
        tlb_q[mp_idx][mp_way].cacheable <= reg_wdata[3];
        tlb_q[mp_idx][mp_way].written   <= reg_wdata[2];
        tlb_q[mp_idx][mp_way].global_pg <= reg_wdata[1];
      end
    end
  end

  // ==========================================================================
  // Fault capture registers; a fault wins over a software write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      entry_high_stage_q <= `XFM_RST_ZERO;
      fault_addr_reg_q   <= `XFM_RST_ZERO;
      exc_event_code_q   <= 12'h000;
    end else if (ce) begin
      if (any_fault) begin
        entry_high_stage_q[31:10] <= req.vaddr[31:10];
        fault_addr_reg_q          <= req.vaddr;
        exc_event_code_q <= fw_fault ? `XFM_CODE_FIRST_WR :
                            (req.write ? `XFM_CODE_INV_STORE
                                       : `XFM_CODE_INV_LOAD);
      end else if (reg_wr) begin
        if (reg_addr == `XFM_OFS_HIGH_STAGE) begin
          entry_high_stage_q <= reg_wdata & 32'hFFFF_FCFF;
        end
        if (reg_addr == `XFM_OFS_FAULT_ADDR) begin
          fault_addr_reg_q <= reg_wdata;
        end
        if (reg_addr == `XFM_OFS_EVENT_CODE) begin
          exc_event_code_q <= reg_wdata[11:0];
        end
      end
    end
  end
  // Control register; a fault overwrites the way pointer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      xlate_control_q <= `XFM_RST_ZERO;
    end else if (ce) begin
      if (any_fault) begin
        xlate_control_q[`XFM_CTL_WAY_LSB +: 2] <= lk_way;
      end else if (reg_wr && reg_addr == `XFM_OFS_CONTROL) begin
        xlate_control_q <= reg_wdata & 32'h0000_01C4;
      end
    end
  end

  // Return state and status word
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      saved_pc_q     <= `XFM_RST_ZERO;
      saved_status_q <= `XFM_RST_ZERO;
      status_word_q  <= `XFM_RST_STATUS;
    end else if (ce) begin
      if (any_fault) begin
        saved_pc_q     <= req.delay_slot ? req.branch_pc : req.pc;
        saved_status_q <= status_word_q;
        status_word_q[`XFM_ST_PRIV_BIT] <= 1'b1;
        status_word_q[`XFM_ST_MASK_BIT] <= 1'b1;
        status_word_q[`XFM_ST_BANK_BIT] <= 1'b1;
      end else if (reg_wr) begin
        if (reg_addr == `XFM_OFS_SAVED_PC) begin
          saved_pc_q <= reg_wdata;
        end
        if (reg_addr == `XFM_OFS_SAVED_STAT) begin
          saved_status_q <= reg_wdata;
        end
        if (reg_addr == `XFM_OFS_STATUS) begin
          status_word_q <= reg_wdata;
        end
      end
    end
  end

  // Stage and base registers, software only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      entry_low_stage_q <= `XFM_RST_ZERO;
      vector_base_q     <= `XFM_RST_ZERO;
    end else if (ce && reg_wr) begin
      if (reg_addr == `XFM_OFS_LOW_STAGE) begin
        entry_low_stage_q <= reg_wdata & 32'h1FFF_FD7E;
      end
      if (reg_addr == `XFM_OFS_VEC_BASE) begin
        vector_base_q <= reg_wdata;
      end
    end
  end

  // ==========================================================================
  // Read data, one cycle after the strobe; unmapped reads give zero
  xfm_pkg::xfm_entry_t rd_e;
  assign rd_e = tlb_q[mp_idx][mp_way];
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata_q <= `XFM_RST_ZERO;
    end else if (ce) begin
      reg_rdata_q <= `XFM_RST_ZERO;
      if (reg_rd) begin
        if (aa_sel) begin
          // Page bits 16-12 are dropped in the read format
          reg_rdata_q <= {rd_e.virt_page_num[21:7], 5'h00, rd_e.virt_page_num[1:0], 1'b0,
                          rd_e.present, rd_e.space_tag};
        end else if (da_sel) begin
          reg_rdata_q <= {3'h0, rd_e.phys_frame_num, 1'b0, rd_e.present, 1'b0,
                          rd_e.rights, rd_e.page_size, rd_e.cacheable,
                          rd_e.written, rd_e.global_pg, 1'b0};
        end else begin
          case (reg_addr)
            `XFM_OFS_HIGH_STAGE: reg_rdata_q <= entry_high_stage_q;
            `XFM_OFS_LOW_STAGE:  reg_rdata_q <= entry_low_stage_q;
            `XFM_OFS_FAULT_ADDR: reg_rdata_q <= fault_addr_reg_q;
            `XFM_OFS_CONTROL:    reg_rdata_q <= xlate_control_q;
            `XFM_OFS_EVENT_CODE: reg_rdata_q <= {20'h00000, exc_event_code_q};
            `XFM_OFS_SAVED_PC:   reg_rdata_q <= saved_pc_q;
            `XFM_OFS_SAVED_STAT: reg_rdata_q <= saved_status_q;
            `XFM_OFS_STATUS:     reg_rdata_q <= status_word_q;
            `XFM_OFS_VEC_BASE:   reg_rdata_q <= vector_base_q;
            default:             reg_rdata_q <= `XFM_RST_ZERO;
          endcase
        end
      end
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_inv_code;
    ce && inv_fault |=> exc_event_code_q ==
      ($past(req.write) ? `XFM_CODE_INV_STORE : `XFM_CODE_INV_LOAD);
  endproperty
  a_inv_code: assert property (p_inv_code) else $error("bad invalid code");
  property p_fw_code;
    ce && fw_fault |=> exc_event_code_q == `XFM_CODE_FIRST_WR;
  endproperty
  a_fw_code: assert property (p_fw_code) else $error("bad first-write code");
  property p_way;
    ce && any_fault |=> way_ptr == $past(lk_way);
  endproperty
  a_way: assert property (p_way) else $error("way not recorded");
  property p_addr;
    ce && any_fault |=> fault_addr_reg_q == $past(req.vaddr) &&
      entry_high_stage_q[31:10] == $past(req.vaddr[31:10]);
  endproperty
  a_addr: assert property (p_addr) else $error("address not captured");
  property p_ret_pc;
    ce && any_fault |=> saved_pc_q ==
      ($past(req.delay_slot) ? $past(req.branch_pc) : $past(req.pc));
  endproperty
  a_ret_pc: assert property (p_ret_pc) else $error("wrong return address");
  property p_stat_save;
    ce && any_fault |=> saved_status_q == $past(status_word_q) &&
      status_word_q[30:28] == 3'h7;
  endproperty
  a_stat_save: assert property (p_stat_save) else $error("status not saved");
  property p_vec;
    ce && any_fault |=> fault_q.valid &&
      fault_q.target == $past(vector_base_q) + `XFM_VEC_OFFSET;
  endproperty
  a_vec: assert property (p_vec) else $error("wrong handler address");
  property p_rd_zero;
    ce && reg_rd && aa_sel |=> reg_rdata_q[16:12] == 5'h00;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read bits not zero");
  property p_no_fw_load;
    ce && req_valid && !req.write |=> !fault_q.valid || $past(inv_fault);
  endproperty
  a_no_fw_load: assert property (p_no_fw_load) else $error("load raised write fault");
  c_inv:   cover property (ce && inv_fault);
  c_fw:    cover property (ce && fw_fault);
  c_assoc: cover property (ce && reg_wr && aa_sel && assoc && |as_hit);
  c_slot:  cover property (ce && any_fault && req.delay_slot);
endmodule : xfm_tlb

/* File: verification/xfm_core_model.sv */
/* Core-side partner: turns one bench command into a lookup or a load pulse.
   Assumes the bench changes its command inputs just after a clock edge. */
module xfm_core_model (
  // Clock
  input  wire logic              clk,
  // Bench command
  input  wire logic              go,
  input  wire logic              ld,
  input  wire xfm_pkg::xfm_req_t cmd,
  // Towards the block
  output xfm_pkg::xfm_req_t      req,
  output logic                   req_valid,
  output logic                   load_entry_op
);
  // ==========================================================================
  // Idle outputs at time zero
  initial begin
    req_valid = 1'b0;
    load_entry_op = 1'b0;
    req = '0;
  end
  // One request a cycle; the idle bus toggles so a stale address never looks valid
  always @(posedge clk) begin
    req_valid <= go;
    req <= go ? cmd : ~req;
    load_entry_op <= ld;
  end
endmodule : xfm_core_model

/* File: verification/tb_top.sv */
/* Random self-checking bench for the translation buffer fault block.
   Assumes the core model file and the package are compiled first. */
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Signals
  logic                clk = 1'b0, rst_n = 1'b0, go = 1'b0, ld = 1'b0;
  logic                reg_wr = 1'b0, reg_rd = 1'b0, req_valid, load_entry_op;
  logic                hit_q, got_f, got_h, kind, wt;
  logic [1:0]          w;
  logic [31:0]         reg_addr = '0, reg_wdata = '0, d, va, vb, s, dv, aa;
  logic [31:0]         paddr_q, reg_rdata_q, status_word_q;
  xfm_pkg::xfm_req_t   cmd = '0, req;
  xfm_pkg::xfm_fault_t fault_q;
  int                  num_errors = 0, checks = 0, cyc = 0;
  // Clock at 250 MHz
  initial begin
    forever #2 clk = ~clk;
  end
  // ==========================================================================
  // Design and core partner
  xfm_tlb dut_u (.clk(clk), .rst_n(rst_n), .ce(1'b1), .req_valid(req_valid), .req(req),
    .load_entry_op(load_entry_op), .hit_q(hit_q), .paddr_q(paddr_q), .fault_q(fault_q),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .status_word_q(status_word_q));
  xfm_core_model core_u (.clk(clk), .go(go), .ld(ld), .cmd(cmd), .req(req),
    .req_valid(req_valid), .load_entry_op(load_entry_op));
  // ==========================================================================
  // Expectations
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], 1'b0} ^ (v[31] ? 32'h04C1_1DB7 : 32'h0);
  endfunction : lfsr
  function automatic logic [11:0] code(input logic k, input logic st);
    return k ? 12'h080 : (st ? 12'h060 : 12'h040);
  endfunction : code
  // Stage word: full rights, 4 KB, cacheable, global so the tag never matters
  function automatic logic [31:0] low(input logic pres, input logic dirty, input logic [18:0] p);
    return {3'h0, p, 1'b0, pres, 1'b0, 2'b11, 1'b1, 1'b1, dirty, 1'b1, 1'b0};
  endfunction : low
  // ==========================================================================
  // Register port and lookup tasks; strobes last one cycle
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_q;
  endtask : rd
  // Fill the stages, point at a way, then pulse the load
  task automatic fill(input logic [31:0] lo);
    wr(32'h0, {va[31:10], 10'h0});
    wr(32'h4, lo);
    wr(32'hC, {24'h0, w, 6'h0});
    @(posedge clk);
    ld <= 1'b1;
    @(posedge clk);
    ld <= 1'b0;
  endtask : fill
  // Both answers are one-cycle pulses, so every cycle is sampled
  task automatic look(input logic st);
    cmd <= '{vaddr: va, write: st, pc: dv, branch_pc: aa, delay_slot: s[4]};
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    got_f = 1'b0;
    got_h = 1'b0;
    repeat (4) begin
      @(posedge clk);
      #1 got_f = got_f | (fault_q.valid === 1'b1);
      got_h = got_h | (hit_q === 1'b1);
    end
  endtask : look
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict
  // Hang guard, far above the well under a thousand cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      print_verdict();
    end
  end
  // ==========================================================================
  // Main sequence
  initial begin
    s = 32'hFD83_1DB4;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 `CHK(status_word_q, 32'h7000_00F0)
    $display("reset test done");
    for (int i = 0; i < 12; i++) begin
      s = lfsr(s); va = s; s = lfsr(s); dv = s; s = lfsr(s); aa = s;
      vb = {s[31:8], 8'h0}; kind = s[0]; w = s[2:1]; wt = s[3] | kind;
      fill(low(kind, 1'b0, s[18:0]));
      // Stale page and way, so only the fault's own capture can pass
      wr(32'h0, 32'h0);
      wr(32'hC, {24'h0, ~w, 6'h0});
      wr(32'h1C, 32'h0000_00F0);
      wr(32'h20, vb);
      look(wt);
      `CHK({got_f, got_h}, 2'b10)
      `CHK(fault_q.target, vb + 32'h100)
      rd(32'h8); `CHK(d, va)
      rd(32'h0); `CHK(d[31:10], va[31:10])
      rd(32'hC); `CHK(d[7:6], w)
      rd(32'h10); `CHK(d[11:0], code(kind, wt))
      rd(32'h14); `CHK(d, s[4] ? aa : dv)
      rd(32'h18); `CHK(d, 32'h0000_00F0)
      `CHK(status_word_q[30:28], 3'b111)
      if (kind) begin
        fill(low(1'b1, 1'b1, s[18:0]));
        look(1'b1); `CHK({got_f, got_h}, 2'b01)
      end
    end
    $display("fault test done");
    dv = {s[31:10], 2'b01, s[7:0]};
    aa = {8'hF2, 7'h0, 5'h15, 4'h2, 8'h0};
    wr(aa, dv); rd(aa); `CHK(d, dv & 32'hFFFE_0DFF)
    wr(aa ^ 32'h280, dv ^ 32'h8000_0000); rd(aa); `CHK(d, dv & 32'hFFFE_0DFF)
    wr(aa ^ 32'h280, dv ^ 32'h100); rd(aa); `CHK(d, dv & 32'hFFFE_0CFF)
    rd(aa ^ 32'h0100_0000); `CHK(d[8], 1'b0)
    wr(32'hC, 32'h4); wr(32'h0, 32'h7); wr(aa, dv); wr(32'hC, 32'h0);
    rd(aa ^ 32'h7000); `CHK(d, dv & 32'hFFFE_0DFF)
    rd(32'h40); `CHK(d, 32'h0)
    wr(32'h1C, 32'h0000_00F0); rd(aa); `CHK(d, 32'h0)
    $display("array test done");
    print_verdict();
  end
endmodule : tb_top
